// >>> internal_memory_map_decode.sv
`timescale 1ns/10ps
`include "memory_map_consts.svh"

// What this block does
// - 16-bit counter, 8K on-chip program storage
// - Program storage is read-only
// - Program counter zero after reset
// - Interrupt vectors at 0003H, eight apart
// - 16-bit data address from pointer pair
// - 256 bytes internal RAM holds stack
// - Above 7FH: direct to SFR, indirect RAM
// - Upper RAM only through indirect access
// - Lower RAM reachable direct and indirect
// - Four banks of eight working registers
// - Sixteen bit-addressable bytes, bits 00H-7FH
// - SFRs ending 000 are bit-addressable
// - Status word at D0H resets 00H
// - Parity flag tracks accumulator every cycle
// - Trap enable picks trap or code read
module internal_memory_map_decode #(
	parameter int PROGRAM_BYTES = `PROGRAM_STORAGE_BYTES,
	parameter int POINTER_BANKS = 8
) (
	input  wire logic                                sys_clk,
	input  wire logic                                rst,
	input  wire logic                                pc_load,
	input  wire logic [15:0]                         pc_load_value,
	input  wire logic                                pc_step,
	input  wire logic                                vector_take,
	input  wire logic [4:0]                          vector_index,
	output logic      [15:0]                         program_counter,
	output logic      [12:0]                         program_rom_addr,
	output logic                                     program_in_range,
	input  wire logic [7:0]                          program_rom_data,
	output logic      [7:0]                          fetch_data,
	input  wire logic                                access_valid,
	input  wire logic                                access_write,
	input  wire memory_map_pkg::access_mode_type     access_mode,
	input  wire logic [7:0]                          access_addr,
	input  wire logic [7:0]                          access_wdata,
	input  wire logic                                access_bit_value,
	output logic      [7:0]                          access_rdata,
	output logic                                     access_bit_rdata,
	output logic                                     access_bit_ok,
	output logic                                     sfr_ext_valid,
	output logic                                     sfr_ext_write,
	output logic      [7:0]                          sfr_ext_addr,
	output logic      [7:0]                          sfr_ext_wdata,
	input  wire logic [7:0]                          sfr_ext_rdata,
	input  wire logic                                pointer_post_inc,
	output logic      [15:0]                         data_pointer_pair,
	output logic                                     trap_select,
	output logic      [7:0]                          stack_pointer_out,
	output logic      [7:0]                          status_word_out
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0]  lower_ram [0:127];
	logic [7:0]  upper_ram [0:127];
	logic [7:0]  stack_pointer;
	logic [7:0]  accumulator;
	logic [7:0]  status_word;
	logic [7:0]  extended_operation;
	logic [7:0]  pointer_low  [0:POINTER_BANKS-1];
	logic [7:0]  pointer_high [0:POINTER_BANKS-1];
	logic [15:0] next_program_counter;
	logic [7:0]  next_stack_pointer;
	logic [7:0]  next_accumulator;
	logic [7:0]  next_status_word;
	logic [7:0]  next_extended_operation;
	logic [7:0]  next_fetch_data;
	logic [7:0]  next_access_rdata;
	logic        next_access_bit_rdata;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	memory_map_pkg::target_type target;
	logic [7:0] byte_addr;
	logic [2:0] bit_pos;
	logic [2:0] pointer_sel;
	logic       bit_ok;
	logic       core_hit;
	logic [7:0] old_byte;
	logic [7:0] new_byte;
	logic       parity;

	assign pointer_sel = extended_operation[2:0];

	always_comb begin
		byte_addr = access_addr;
		bit_pos   = 3'h0;
		bit_ok    = 1'b1;
		case (access_mode)
			memory_map_pkg::mode_register: begin
				byte_addr = {3'h0, status_word[`STATUS_BANK_HIGH_BIT],
					status_word[`STATUS_BANK_LOW_BIT], access_addr[2:0]};
			end
			memory_map_pkg::mode_bit: begin
				bit_pos = access_addr[2:0];
				if (access_addr <= `LOWER_RAM_TOP) begin
					byte_addr = `BIT_AREA_BASE + {4'h0, access_addr[6:3]};
				end else begin
					byte_addr = {access_addr[7:3], 3'h0};
				end
			end
			default: begin
				bit_ok = 1'b1;
			end
		endcase
		if (byte_addr <= `LOWER_RAM_TOP) begin
			target = memory_map_pkg::target_lower_ram;
		end else if (access_mode == memory_map_pkg::mode_indirect) begin
			target = memory_map_pkg::target_upper_ram;
		end else begin
			target = memory_map_pkg::target_sfr;
		end
	end

	always_comb begin
		case (byte_addr)
			`ADDR_STACK_POINTER,
			`ADDR_DATA_POINTER_LOW,
			`ADDR_DATA_POINTER_HIGH,
			`ADDR_EXTENDED_OPERATION,
			`ADDR_STATUS_WORD,
			`ADDR_ACCUMULATOR: core_hit = 1'b1;
			default:           core_hit = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always_comb begin
		old_byte = 8'h00;
		case (target)
			memory_map_pkg::target_lower_ram: old_byte = lower_ram[byte_addr[6:0]];
			memory_map_pkg::target_upper_ram: old_byte = upper_ram[byte_addr[6:0]];
			default: begin
				case (byte_addr)
					`ADDR_STACK_POINTER:      old_byte = stack_pointer;
					`ADDR_DATA_POINTER_LOW:   old_byte = pointer_low[pointer_sel];
					`ADDR_DATA_POINTER_HIGH:  old_byte = pointer_high[pointer_sel];
					`ADDR_EXTENDED_OPERATION: old_byte = extended_operation & `EXT_WRITABLE_MASK;
					`ADDR_STATUS_WORD:        old_byte = status_word;
					`ADDR_ACCUMULATOR:        old_byte = accumulator;
					default:                  old_byte = sfr_ext_rdata;
				endcase
			end
		endcase
		new_byte = access_wdata;
		if (access_mode == memory_map_pkg::mode_bit) begin
			new_byte = old_byte;
			new_byte[bit_pos] = access_bit_value;
		end
	end

	assign access_bit_ok  = bit_ok;
	assign sfr_ext_valid  = access_valid && target == memory_map_pkg::target_sfr && !core_hit;
	assign sfr_ext_write  = access_write;
	assign sfr_ext_addr   = byte_addr;
	assign sfr_ext_wdata  = new_byte;

	// ----------------------------------------
	// Next values of core registers
	// ----------------------------------------
	logic core_write;

	assign core_write = access_valid && access_write &&
		target == memory_map_pkg::target_sfr;

	always_comb begin
		next_stack_pointer      = stack_pointer;
		next_accumulator        = accumulator;
		next_status_word        = status_word;
		next_extended_operation = extended_operation;
		if (core_write) begin
			case (byte_addr)
				`ADDR_STACK_POINTER: next_stack_pointer = new_byte;
				`ADDR_ACCUMULATOR:   next_accumulator   = new_byte;
				`ADDR_STATUS_WORD:   next_status_word   = new_byte;
				`ADDR_EXTENDED_OPERATION: begin
					next_extended_operation = new_byte & `EXT_WRITABLE_MASK;
				end
				default: next_stack_pointer = stack_pointer;
			endcase
		end
		parity = ^next_accumulator;
		next_status_word[`STATUS_PARITY_BIT] = parity;
	end

	always_comb begin
		next_access_rdata     = old_byte;
		next_access_bit_rdata = old_byte[bit_pos];
	end

	// ----------------------------------------
	// Program counter
	// ----------------------------------------
	always_comb begin
		next_program_counter = program_counter;
		if (vector_take) begin
			next_program_counter = `VECTOR_BASE + {8'h00, vector_index, 3'h0};
		end else if (pc_load) begin
			next_program_counter = pc_load_value;
		end else if (pc_step) begin
			next_program_counter = program_counter + 16'h0001;
		end
		next_fetch_data = (program_counter < 16'(PROGRAM_BYTES)) ? program_rom_data : 8'hFF;
	end

	// Program storage has no write port
	assign program_rom_addr = program_counter[12:0];
	assign program_in_range = program_counter < 16'(PROGRAM_BYTES);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			program_counter    <= `RESET_PROGRAM_COUNTER;
			status_word        <= `RESET_STATUS_WORD;
			extended_operation <= `RESET_EXTENDED_OPERATION;
			stack_pointer      <= `RESET_STACK_POINTER;
			accumulator        <= 8'h00;
			fetch_data         <= 8'h00;
			access_rdata       <= 8'h00;
			access_bit_rdata   <= 1'b0;
		end else begin
			program_counter    <= next_program_counter;
			status_word        <= next_status_word;
			extended_operation <= next_extended_operation;
			stack_pointer      <= next_stack_pointer;
			accumulator        <= next_accumulator;
			fetch_data         <= next_fetch_data;
			access_rdata       <= next_access_rdata;
			access_bit_rdata   <= next_access_bit_rdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (access_valid && access_write) begin
			if (target == memory_map_pkg::target_lower_ram) begin
				lower_ram[byte_addr[6:0]] <= new_byte;
			end
			if (target == memory_map_pkg::target_upper_ram) begin
				upper_ram[byte_addr[6:0]] <= new_byte;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (core_write && byte_addr == `ADDR_DATA_POINTER_LOW) begin
			pointer_low[pointer_sel] <= new_byte;
		end else if (core_write && byte_addr == `ADDR_DATA_POINTER_HIGH) begin
			pointer_high[pointer_sel] <= new_byte;
		end else if (pointer_post_inc) begin
			{pointer_high[pointer_sel], pointer_low[pointer_sel]} <= data_pointer_pair + 16'h0001;
		end
	end

	assign data_pointer_pair = {pointer_high[pointer_sel], pointer_low[pointer_sel]};
	assign trap_select       = extended_operation[`EXT_TRAP_ENABLE_BIT];
	assign stack_pointer_out = stack_pointer;
	assign status_word_out   = status_word;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_reset_pc_zero: assert property (
		@(posedge sys_clk) rst |=> program_counter == 16'h0000)
		else $error("pc not zero after reset");
	a_vector_slot: assert property (@(posedge sys_clk) disable iff (rst)
		vector_take |=> program_counter == 16'h0003 + {8'h00, $past(vector_index), 3'h0})
		else $error("bad vector address");
	a_direct_no_upper: assert property (@(posedge sys_clk) disable iff (rst)
		access_mode == memory_map_pkg::mode_direct |->
		target != memory_map_pkg::target_upper_ram)
		else $error("direct access hit upper ram");
	a_indirect_upper: assert property (@(posedge sys_clk) disable iff (rst)
		access_mode == memory_map_pkg::mode_indirect && access_addr[7] |->
		target == memory_map_pkg::target_upper_ram && !sfr_ext_valid)
		else $error("indirect high access not upper ram");
	a_parity_tracks: assert property (@(posedge sys_clk) disable iff (rst)
		##1 status_word[0] == ^accumulator)
		else $error("parity flag wrong");
	a_ext_readonly: assert property (@(posedge sys_clk) disable iff (rst)
		(extended_operation & 8'hE8) == 8'h00)
		else $error("read-only bits set");
	a_bank_addr: assert property (@(posedge sys_clk) disable iff (rst)
		access_mode == memory_map_pkg::mode_register |->
		byte_addr == {3'h0, status_word[4:3], access_addr[2:0]})
		else $error("bank address wrong");
	a_status_reset: assert property (
		@(posedge sys_clk) rst |=> status_word == 8'h00)
		else $error("status word not reset");
	a_trap_follows: assert property (@(posedge sys_clk) disable iff (rst)
		core_write && byte_addr == 8'hA2 |=> trap_select == $past(new_byte[4]))
		else $error("trap select not written");
	a_core_not_ext: assert property (@(posedge sys_clk) disable iff (rst)
		core_hit |-> !sfr_ext_valid)
		else $error("core register reached sfr port");
	a_fetch_blank: assert property (@(posedge sys_clk) disable iff (rst)
		!program_in_range |=> fetch_data == 8'hFF)
		else $error("fetch outside storage not blank");
	a_sfr_bit_column: assert property (@(posedge sys_clk) disable iff (rst)
		access_mode == memory_map_pkg::mode_bit && access_addr[7] |->
		byte_addr[2:0] == 3'h0 && target == memory_map_pkg::target_sfr)
		else $error("sfr bit outside column");

	// Post-increment step of the selected pointer pair
	sequence s_pointer_bump;
		pointer_post_inc && !core_write;
	endsequence

	a_pointer_bump: assert property (@(posedge sys_clk) disable iff (rst)
		s_pointer_bump |=> data_pointer_pair == $past(data_pointer_pair) + 16'h0001)
		else $error("pointer pair not incremented");

endmodule

// >>> internal_memory_map_decode_tb_top.sv
`timescale 1ns/10ps

module internal_memory_map_decode_tb_top;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic pc_load, pc_step, vector_take, program_in_range, access_valid, access_write;
	logic access_bit_value, access_bit_rdata, access_bit_ok, sfr_ext_valid, sfr_ext_write;
	logic pointer_post_inc, trap_select, rb;
	logic [4:0] vector_index;
	logic [12:0] program_rom_addr;
	logic [15:0] pc_load_value, program_counter, data_pointer_pair;
	logic [7:0] program_rom_data, fetch_data, access_addr, access_wdata, access_rdata;
	logic [7:0] sfr_ext_addr, sfr_ext_wdata, sfr_ext_rdata, stack_pointer_out, status_word_out;
	logic [7:0] rd, v, a, old;
	logic [15:0] dp [8];
	memory_map_pkg::access_mode_type access_mode;
	int n_fail = 0;
	int compares = 0;
	int seed = 32'h00ECF35F;

	always #4 sys_clk = ~sys_clk;

	internal_memory_map_decode u_internal_memory_map_decode (
		.sys_clk(sys_clk), .rst(rst), .pc_load(pc_load), .pc_load_value(pc_load_value),
		.pc_step(pc_step), .vector_take(vector_take), .vector_index(vector_index),
		.program_counter(program_counter), .program_rom_addr(program_rom_addr),
		.program_in_range(program_in_range), .program_rom_data(program_rom_data),
		.fetch_data(fetch_data), .access_valid(access_valid), .access_write(access_write),
		.access_mode(access_mode), .access_addr(access_addr), .access_wdata(access_wdata),
		.access_bit_value(access_bit_value), .access_rdata(access_rdata),
		.access_bit_rdata(access_bit_rdata), .access_bit_ok(access_bit_ok),
		.sfr_ext_valid(sfr_ext_valid), .sfr_ext_write(sfr_ext_write),
		.sfr_ext_addr(sfr_ext_addr), .sfr_ext_wdata(sfr_ext_wdata),
		.sfr_ext_rdata(sfr_ext_rdata), .pointer_post_inc(pointer_post_inc),
		.data_pointer_pair(data_pointer_pair), .trap_select(trap_select),
		.stack_pointer_out(stack_pointer_out), .status_word_out(status_word_out));
	sfr_rom_model u_sfr_rom_model (
		.sys_clk(sys_clk), .program_rom_addr(program_rom_addr),
		.sfr_ext_valid(sfr_ext_valid), .sfr_ext_addr(sfr_ext_addr),
		.program_rom_data(program_rom_data), .sfr_ext_rdata(sfr_ext_rdata));

	function automatic logic [7:0] rom_byte(input logic [12:0] x);
		return x[7:0] ^ x[12:5] ^ 8'h5A;
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic acc(input logic w, input memory_map_pkg::access_mode_type m,
			input logic [7:0] ad, input logic [7:0] d, input logic b);
		@(posedge sys_clk);
		#1;
		access_valid = 1'b1;
		access_write = w;
		access_mode = m;
		access_addr = ad;
		access_wdata = d;
		access_bit_value = b;
		@(posedge sys_clk);
		#1;
		access_valid = 1'b0;
		rd = access_rdata;
		rb = access_bit_rdata;
	endtask

	task automatic pc_op(input logic ld, input logic st, input logic vt,
			input logic [4:0] vi, input logic [15:0] lv);
		@(posedge sys_clk);
		#1;
		{pc_load, pc_step, vector_take, vector_index, pc_load_value} = {ld, st, vt, vi, lv};
		@(posedge sys_clk);
		#1;
		{pc_load, pc_step, vector_take} = 3'b000;
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		report_and_stop;
	end

	initial begin
		{pc_load, pc_step, vector_take, vector_index, pc_load_value} = '0;
		{access_valid, access_write, access_addr, access_wdata, access_bit_value} = '0;
		access_mode = memory_map_pkg::mode_direct;
		pointer_post_inc = 1'b0;
		repeat (6) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		chk(program_counter, 16'h0000);
		chk(status_word_out, 8'h00);
		chk(stack_pointer_out, 8'h07);
		acc(1'b0, memory_map_pkg::mode_direct, 8'hA2, 8'h00, 1'b0);
		chk(rd, 8'h00);
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
			acc(1'b1, memory_map_pkg::mode_direct, 8'hE0, v, 1'b0);
			chk(status_word_out[0], ^v);
		end
		acc(1'b1, memory_map_pkg::mode_direct, 8'hA2, 8'hFF, 1'b0);
		chk(trap_select, 1'b1);
		acc(1'b0, memory_map_pkg::mode_direct, 8'hA2, 8'h00, 1'b0);
		chk(rd, 8'h17);
		$display("accumulator and extended test done");
		for (int k = 0; k < 8; k++) begin
			dp[k] = 16'($random(seed));
			acc(1'b1, memory_map_pkg::mode_direct, 8'hA2, 8'(k), 1'b0);
			acc(1'b1, memory_map_pkg::mode_direct, 8'h82, dp[k][7:0], 1'b0);
			acc(1'b1, memory_map_pkg::mode_direct, 8'h83, dp[k][15:8], 1'b0);
		end
		for (int k = 0; k < 8; k++) begin
			acc(1'b1, memory_map_pkg::mode_direct, 8'hA2, 8'(k), 1'b0);
			chk(trap_select, 1'b0);
			chk(data_pointer_pair, dp[k]);
			pointer_post_inc = 1'b1;
			@(posedge sys_clk);
			#1;
			pointer_post_inc = 1'b0;
			chk(data_pointer_pair, dp[k] + 16'h0001);
		end
		$display("pointer bank test done");
		for (int i = 0; i < 8; i++) begin
			a = (i == 0) ? 8'h7F : {1'b0, 7'($random(seed))};
			v = 8'($random(seed));
			acc(1'b1, memory_map_pkg::mode_direct, a, v, 1'b0);
			acc(1'b0, memory_map_pkg::mode_indirect, a, 8'h00, 1'b0);
			chk(rd, v);
		end
		for (int i = 0; i < 4; i++) begin
			a = 8'h84 + 8'(i * 29);
			v = 8'($random(seed));
			acc(1'b1, memory_map_pkg::mode_indirect, a, v, 1'b0);
			acc(1'b0, memory_map_pkg::mode_indirect, a, 8'h00, 1'b0);
			chk(rd, v);
			acc(1'b0, memory_map_pkg::mode_direct, a, 8'h00, 1'b0);
			chk(rd, {8'h00, ~a});
		end
		@(posedge sys_clk);
		#1;
		access_valid = 1'b1;
		access_write = 1'b1;
		access_mode = memory_map_pkg::mode_direct;
		access_addr = 8'hC5;
		access_wdata = 8'h3C;
		#1;
		chk({sfr_ext_valid, sfr_ext_write, access_bit_ok}, 3'b111);
		chk({sfr_ext_addr, sfr_ext_wdata}, 16'hC53C);
		@(posedge sys_clk);
		#1;
		access_valid = 1'b0;
		$display("ram space test done");
		for (int b = 0; b < 4; b++) begin
			acc(1'b1, memory_map_pkg::mode_direct, 8'hD0, 8'(b << 3), 1'b0);
			a = 8'($random(seed)) & 8'h07;
			v = 8'($random(seed));
			acc(1'b1, memory_map_pkg::mode_register, a, v, 1'b0);
			acc(1'b0, memory_map_pkg::mode_direct, 8'(b * 8) + a, 8'h00, 1'b0);
			chk(rd, v);
		end
		$display("register bank test done");
		for (int i = 0; i < 6; i++) begin
			a = (i == 0) ? 8'h7F : (i == 1) ? 8'h00 : {1'b0, 7'($random(seed))};
			old = 8'($random(seed));
			acc(1'b1, memory_map_pkg::mode_direct, 8'h20 + 8'(a[6:3]), old, 1'b0);
			acc(1'b1, memory_map_pkg::mode_bit, a, 8'h00, ~old[a[2:0]]);
			acc(1'b0, memory_map_pkg::mode_direct, 8'h20 + 8'(a[6:3]), 8'h00, 1'b0);
			chk(rd, old ^ (8'h01 << a[2:0]));
		end
		acc(1'b1, memory_map_pkg::mode_direct, 8'hD0, 8'h00, 1'b0);
		acc(1'b1, memory_map_pkg::mode_bit, 8'hD3, 8'h00, 1'b1);
		chk(status_word_out[4:3], 2'b01);
		acc(1'b0, memory_map_pkg::mode_bit, 8'hD3, 8'h00, 1'b0);
		chk(rb, 1'b1);
		$display("bit address test done");
		pc_op(1'b1, 1'b0, 1'b0, 5'd0, 16'h1FFF);
		chk(program_rom_addr, 13'h1FFF);
		@(posedge sys_clk);
		#1;
		chk(fetch_data, rom_byte(13'h1FFF));
		pc_op(1'b0, 1'b1, 1'b0, 5'd0, 16'h0000);
		chk(program_counter, 16'h2000);
		chk(program_in_range, 1'b0);
		@(posedge sys_clk);
		#1;
		chk(fetch_data, 8'hFF);
		for (int i = 0; i < 32; i += 5) begin
			pc_op(1'b1, 1'b0, 1'b1, 5'(i), 16'h1234);
			chk(program_counter, 16'h0003 + 16'(8 * i));
		end
		$display("program counter test done");
		report_and_stop;
	end
endmodule

// >>> memory_map_consts.svh
`ifndef MEMORY_MAP_CONSTS_SVH
`define MEMORY_MAP_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_STACK_POINTER       8'h81
`define ADDR_DATA_POINTER_LOW    8'h82
`define ADDR_DATA_POINTER_HIGH   8'h83
`define ADDR_EXTENDED_OPERATION  8'hA2
`define ADDR_STATUS_WORD         8'hD0
`define ADDR_ACCUMULATOR         8'hE0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RESET_STATUS_WORD        8'h00
`define RESET_EXTENDED_OPERATION 8'h00
`define RESET_STACK_POINTER      8'h07
`define RESET_PROGRAM_COUNTER    16'h0000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define STATUS_PARITY_BIT        0
`define STATUS_BANK_LOW_BIT      3
`define STATUS_BANK_HIGH_BIT     4
`define EXT_TRAP_ENABLE_BIT      4
`define EXT_WRITABLE_MASK        8'h17

// ----------------------------------------
// Address space limits
// ----------------------------------------
`define LOWER_RAM_TOP            8'h7F
`define BIT_AREA_BASE            8'h20
`define PROGRAM_STORAGE_BYTES    8192
`define VECTOR_BASE              16'h0003
`define VECTOR_SPACING           16'h0008

`endif

// >>> memory_map_pkg.sv
package memory_map_pkg;

	typedef enum logic [1:0] {
		target_lower_ram = 2'b00,
		target_upper_ram = 2'b01,
		target_sfr       = 2'b10
	} target_type;

	typedef enum logic [1:0] {
		mode_direct   = 2'b00,
		mode_indirect = 2'b01,
		mode_bit      = 2'b10,
		mode_register = 2'b11
	} access_mode_type;

endpackage

// >>> sfr_rom_model.sv
`timescale 1ns/10ps

// ----------------------------------------
// Program store and peripheral SFR stand-in
// ----------------------------------------
module sfr_rom_model (
	input  wire logic        sys_clk,
	input  wire logic [12:0] program_rom_addr,
	input  wire logic        sfr_ext_valid,
	input  wire logic [7:0]  sfr_ext_addr,
	output logic      [7:0]  program_rom_data,
	output logic      [7:0]  sfr_ext_rdata
);
	logic [7:0] idle_pattern = 8'h00;

	always @(posedge sys_clk) begin
		idle_pattern <= idle_pattern + 8'h3B;
	end

	assign program_rom_data = program_rom_addr[7:0] ^ program_rom_addr[12:5] ^ 8'h5A;
	// Unselected bus shows a moving pattern
	assign sfr_ext_rdata = sfr_ext_valid ? ~sfr_ext_addr : idle_pattern;
endmodule
